// ### src/vec_irq_pkg.sv
// constants for the vectored priority interrupt controller
// assumes one 50 MHz clock and an asynchronous active-low reset
// How it works
// - higher pending level wins each arbitration; a presented vector is not preempted
// - same level: smallest vector number wins
// - vector address is base plus twice number
// - vector targets limited to nineteen bits, except the two reset slot addresses
// - resets use slots zero and one
// - reset base overlays chip reset addresses
// - core exceptions two to five, level three
// - debug, power, clock sources levels one-three
// - peripherals from sixteen take levels zero-two
// - vector sixty-six below every level
// - converter limit conditions share vector twenty-two
// - pulse sub-module three separate requests, capture 46
// - flash three requests, completion on fifty-five
// - debug transmit empty on vector nine
package vec_irq_pkg;
    // ------------------------------------------------------------
    // table shape
    // ------------------------------------------------------------
    localparam int NUM_VEC = 67;
    localparam int ADDR_W = 21;
    localparam int TARGET_W = 19;
    localparam int VEC_W = 7;
    localparam logic [ADDR_W-1:0] BASE_RESET = 21'h000000;
    localparam logic [ADDR_W-1:0] CHIP_RESET_ADDR = 21'h000000;
    localparam logic [ADDR_W-1:0] WDOG_RESET_OFFS = 21'h000002;
    // ------------------------------------------------------------
    // fixed vector numbers
    // ------------------------------------------------------------
    localparam int VEC_CHIP_RESET = 0;
    localparam int VEC_WDOG_RESET = 1;
    localparam int VEC_EXC_FIRST = 2;
    localparam int VEC_EXC_LAST = 5;
    localparam int VEC_DBG_FIRST = 6;
    localparam int VEC_DBG_TX_EMPTY = 9;
    localparam int VEC_DBG_LAST = 10;
    localparam int VEC_SWI2 = 11;
    localparam int VEC_SWI1 = 12;
    localparam int VEC_SWI0 = 13;
    localparam int VEC_POWER_MON = 14;
    localparam int VEC_CLOCK_LOSS = 15;
    localparam int VEC_PERIPH_FIRST = 16;
    localparam int VEC_CONV_LIMIT = 22;
    localparam int VEC_PWM3_RELOAD = 45;
    localparam int VEC_PWM3_CAPTURE = 46;
    localparam int VEC_PWM3_COMPARE = 47;
    localparam int VEC_FLASH_ERR = 54;
    localparam int VEC_FLASH_DONE = 55;
    localparam int VEC_FLASH_EMPTY = 56;
    localparam int VEC_PERIPH_LAST = 65;
    localparam int VEC_SOFT_LOW = 66;
    // ------------------------------------------------------------
    // encoded levels: 0 means none, 1 means minus one, 2..5 mean levels 0..3
    // ------------------------------------------------------------
    localparam logic [2:0] LVL_NONE = 3'h0;
    localparam logic [2:0] LVL_M1 = 3'h1;
    localparam logic [2:0] LVL_0 = 3'h2;
    localparam logic [2:0] LVL_1 = 3'h3;
    localparam logic [2:0] LVL_2 = 3'h4;
    localparam logic [2:0] LVL_3 = 3'h5;
    typedef enum logic [0:0] {IDLE, PRESENT} state_t;
endpackage

// ### src/vec_irq_ctrl.sv
// vectored priority interrupt arbiter and vector address former
// assumes request lines are synchronous to clk and hold until served
`timescale 1ns/10ps
module vec_irq_ctrl #(
    parameter int NUM_VEC = vec_irq_pkg::NUM_VEC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // vector base, from the core's base register
    input wire logic [vec_irq_pkg::ADDR_W-1:0] vectorBaseAddress,
    // core exception requests, vectors two to five
    input wire logic [3:0] excReq,
    // debug port requests, vectors six to ten, and their levels 1..3
    input wire logic [4:0] dbgReq,
    input wire logic [9:0] dbgLevel,
    // fixed-level software interrupts two, one, zero
    input wire logic [2:0] swiReq,
    // power monitor and clock loss, levels 1..3
    input wire logic powerMonReq,
    input wire logic [1:0] powerMonLevel,
    input wire logic clockLossReq,
    input wire logic [1:0] clockLossLevel,
    // converter limit conditions: zero crossing, low, high
    input wire logic [2:0] convLimitReq,
    // peripheral requests, vectors sixteen to sixty-five, levels 0..2
    input wire logic [49:0] periphReq,
    input wire logic [99:0] periphLevel,
    // lowest software interrupt
    input wire logic softLowReq,
    // core side
    input wire logic coreAck,
    output logic irqValid,
    output logic [vec_irq_pkg::ADDR_W-1:0] irqAddr,
    output logic [vec_irq_pkg::VEC_W-1:0] irqVector,
    // fixed reset fetch addresses
    output logic [vec_irq_pkg::ADDR_W-1:0] chipResetAddr,
    output logic [vec_irq_pkg::ADDR_W-1:0] wdogResetAddr
);
    // ------------------------------------------------------------
    // per-vector request and level
    // ------------------------------------------------------------
    logic [NUM_VEC-1:0] pend;
    logic [2:0] lvl [NUM_VEC];
    logic [1:0] pl;
    logic [1:0] dl;

    // map every source onto its vector slot with its level
    always_comb begin
        for (int v = 0; v < NUM_VEC; v++) begin
            pend[v] = 1'b0;
            lvl[v] = vec_irq_pkg::LVL_NONE;
        end
        for (int v = vec_irq_pkg::VEC_EXC_FIRST; v <= vec_irq_pkg::VEC_EXC_LAST; v++) begin
            pend[v] = excReq[v-vec_irq_pkg::VEC_EXC_FIRST];
            lvl[v] = vec_irq_pkg::LVL_3;
        end
        for (int v = vec_irq_pkg::VEC_DBG_FIRST; v <= vec_irq_pkg::VEC_DBG_LAST; v++) begin
            pend[v] = dbgReq[v-vec_irq_pkg::VEC_DBG_FIRST];
            dl = dbgLevel[2*(v-vec_irq_pkg::VEC_DBG_FIRST) +: 2];
            lvl[v] = (dl == 2'h0) ? vec_irq_pkg::LVL_1 : 3'(vec_irq_pkg::LVL_0 + 3'(dl));
        end
        pend[vec_irq_pkg::VEC_SWI2] = swiReq[2];
        lvl[vec_irq_pkg::VEC_SWI2] = vec_irq_pkg::LVL_2;
        pend[vec_irq_pkg::VEC_SWI1] = swiReq[1];
        lvl[vec_irq_pkg::VEC_SWI1] = vec_irq_pkg::LVL_1;
        pend[vec_irq_pkg::VEC_SWI0] = swiReq[0];
        lvl[vec_irq_pkg::VEC_SWI0] = vec_irq_pkg::LVL_0;
        // level code 0 is out of range for these; it is raised to level one
        pend[vec_irq_pkg::VEC_POWER_MON] = powerMonReq;
        lvl[vec_irq_pkg::VEC_POWER_MON] = (powerMonLevel == 2'h0) ? vec_irq_pkg::LVL_1 :
            3'(vec_irq_pkg::LVL_0 + 3'(powerMonLevel));
        pend[vec_irq_pkg::VEC_CLOCK_LOSS] = clockLossReq;
        lvl[vec_irq_pkg::VEC_CLOCK_LOSS] = (clockLossLevel == 2'h0) ? vec_irq_pkg::LVL_1 :
            3'(vec_irq_pkg::LVL_0 + 3'(clockLossLevel));
        for (int v = vec_irq_pkg::VEC_PERIPH_FIRST; v <= vec_irq_pkg::VEC_PERIPH_LAST; v++) begin
            pend[v] = periphReq[v-vec_irq_pkg::VEC_PERIPH_FIRST];
            pl = periphLevel[2*(v-vec_irq_pkg::VEC_PERIPH_FIRST) +: 2];
            // code 3 is illegal for peripherals; it is clamped to level two
            lvl[v] = (pl == 2'h3) ? vec_irq_pkg::LVL_2 : 3'(vec_irq_pkg::LVL_0 + 3'(pl));
        end
        // three converter conditions merge into one request
        // the slot's own peripheral bit is kept, so neither source hides the other
        pend[vec_irq_pkg::VEC_CONV_LIMIT] = periphReq[vec_irq_pkg::VEC_CONV_LIMIT-vec_irq_pkg::VEC_PERIPH_FIRST] |
            (|convLimitReq);
        pend[vec_irq_pkg::VEC_SOFT_LOW] = softLowReq;
        lvl[vec_irq_pkg::VEC_SOFT_LOW] = vec_irq_pkg::LVL_M1;
    end
    // pulse sub-module three and flash inputs keep their own bits in periphReq,
    // vectors 45/46/47 and 54/55/56, so each is served on its own slot

    // ------------------------------------------------------------
    // arbitration: highest level, then lowest vector number
    // ------------------------------------------------------------
    logic winFound;
    logic [2:0] winLvl;
    logic [vec_irq_pkg::VEC_W-1:0] winVec;

    // walking upward, only a strictly higher level replaces the winner,
    // so ties keep the smaller vector
    always_comb begin
        winFound = 1'b0;
        winLvl = vec_irq_pkg::LVL_NONE;
        winVec = '0;
        for (int v = vec_irq_pkg::VEC_EXC_FIRST; v < NUM_VEC; v++) begin
            if (pend[v] && lvl[v] > winLvl) begin
                winFound = 1'b1;
                winLvl = lvl[v];
                winVec = vec_irq_pkg::VEC_W'(v);
            end
        end
    end

    // ------------------------------------------------------------
    // vector address: base plus twice the number, nineteen-bit reach
    // ------------------------------------------------------------
    logic [vec_irq_pkg::ADDR_W-1:0] nxt_addr;
    always_comb begin
        nxt_addr = vectorBaseAddress + {{(vec_irq_pkg::ADDR_W-vec_irq_pkg::VEC_W-1){1'b0}}, winVec, 1'b0};
        nxt_addr = {{(vec_irq_pkg::ADDR_W-vec_irq_pkg::TARGET_W){1'b0}},
            nxt_addr[vec_irq_pkg::TARGET_W-1:0]};
    end

    // ------------------------------------------------------------
    // core handshake: hold the presented vector until acknowledged
    // ------------------------------------------------------------
    vec_irq_pkg::state_t state_ff;
    logic [vec_irq_pkg::ADDR_W-1:0] addr_ff;
    logic [vec_irq_pkg::VEC_W-1:0] vec_ff;

    // a later higher request waits: swapping the vector under the core mid-fetch is unsafe
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= vec_irq_pkg::IDLE;
        end else begin
            unique case (state_ff)
                vec_irq_pkg::IDLE: begin
                    if (winFound) begin
                        state_ff <= vec_irq_pkg::PRESENT;
                    end
                end
                vec_irq_pkg::PRESENT: begin
                    if (coreAck) begin
                        state_ff <= vec_irq_pkg::IDLE;
                    end
                end
            endcase
        end
    end

    // latch address and number on entry to present
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            addr_ff <= '0;
            vec_ff <= '0;
        end else if (state_ff == vec_irq_pkg::IDLE && winFound) begin
            addr_ff <= nxt_addr;
            vec_ff <= winVec;
        end
    end

    assign irqValid = (state_ff == vec_irq_pkg::PRESENT);
    assign irqAddr = addr_ff;
    assign irqVector = vec_ff;

    // reset slots zero and one; with the reset base slot zero sits on the chip reset address, slot one two above it
    assign chipResetAddr = vectorBaseAddress + vec_irq_pkg::CHIP_RESET_ADDR;
    assign wdogResetAddr = vectorBaseAddress + vec_irq_pkg::WDOG_RESET_OFFS;
endmodule

// ### dv/vec_irq_chk.sv
// checker for the arbiter's core-side outputs
// assumes one clock domain and binding onto vec_irq_ctrl
`timescale 1ns/10ps
module vec_irq_chk (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // watched ports
    input wire logic [20:0] vectorBaseAddress,
    input wire logic [3:0] excReq,
    input wire logic [2:0] swiReq,
    input wire logic coreAck,
    input wire logic irqValid,
    input wire logic [20:0] irqAddr,
    input wire logic [6:0] irqVector,
    input wire logic [20:0] chipResetAddr,
    input wire logic [20:0] wdogResetAddr
);
    // --------------------------------
    // properties
    // --------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    a_addr_form: assert property (irqValid |-> irqAddr == ((vectorBaseAddress + {irqVector, 1'b0}) & 21'h07ffff))
        else $error("vector address wrong");
    a_hold_ack: assert property (irqValid && !coreAck |=> irqValid && $stable(irqAddr) && $stable(irqVector))
        else $error("presented vector not held");
    a_drop_ack: assert property (irqValid && coreAck |=> !irqValid)
        else $error("valid stays after ack");
    a_chip_base: assert property (chipResetAddr == vectorBaseAddress)
        else $error("chip reset slot wrong");
    a_wdog_base: assert property (wdogResetAddr == vectorBaseAddress + 21'h000002)
        else $error("watchdog reset slot wrong");
    a_exc_first: assert property (excReq[0] && !irqValid |=> irqValid && irqVector == 7'h02)
        else $error("illegal instruction not first");
    a_exc_top: assert property ($rose(irqValid) && $past(excReq) != 4'h0 |-> irqVector inside {[2:5]})
        else $error("exception lost to lower level");
    a_low_last: assert property ($rose(irqValid) && irqVector == 7'h42 |-> $past(excReq) == 4'h0 && $past(swiReq) == 3'h0)
        else $error("lowest soft irq jumped ahead");
endmodule
bind vec_irq_ctrl vec_irq_chk u_chk (.clk, .rstn, .vectorBaseAddress, .excReq, .swiReq, .coreAck, .irqValid,
    .irqAddr, .irqVector, .chipResetAddr, .wdogResetAddr);

// ### dv/core_model.sv
// core that fetches a presented vector and acknowledges it
// assumes irqValid holds until the ack edge
`timescale 1ns/10ps
module core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // arbiter side
    input wire logic irqValid,
    input wire logic [3:0] ackDelay,
    output logic coreAck
);
    logic [3:0] waitCnt_ff;
    // one-cycle ack after a chosen wait; slow waits exercise the hold
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            waitCnt_ff <= 4'h0;
            coreAck <= 1'b0;
        end else if (irqValid && !coreAck && waitCnt_ff == ackDelay) begin
            coreAck <= 1'b1;
            waitCnt_ff <= 4'h0;
        end else begin
            coreAck <= 1'b0;
            waitCnt_ff <= (irqValid && !coreAck) ? waitCnt_ff + 4'h1 : 4'h0;
        end
    end
endmodule

// ### dv/tb_vectored_priority_interrupt_ctrl.sv
// bench for the vector arbiter, core model acknowledges
// assumes sources hold requests until the bench clears them
`timescale 1ns/10ps
module tb_vectored_priority_interrupt_ctrl;
    logic clk = 1'b0, rstn = 1'b0, powerMonReq = 1'b0, clockLossReq = 1'b0, softLowReq = 1'b0;
    logic [20:0] vectorBaseAddress = 21'h000000;
    logic [3:0] excReq = 4'h0, ackDelay = 4'h0;
    logic [4:0] dbgReq = 5'h00;
    logic [9:0] dbgLevel = 10'h000;
    logic [2:0] swiReq = 3'h0, convLimitReq = 3'h0;
    logic [1:0] powerMonLevel = 2'h1, clockLossLevel = 2'h1;
    logic [49:0] periphReq = '0;
    logic [99:0] periphLevel = '0;
    logic coreAck, irqValid;
    logic [20:0] irqAddr, chipResetAddr, wdogResetAddr;
    logic [6:0] irqVector;
    int n_fail = 0, n_tests = 0, cycles = 0;
    int ordA[8] = '{9, 15, 11, 22, 12, 14, 13, 66};
    int ordB[4] = '{45, 46, 55, 47};
    vec_irq_ctrl u_dut (.clk, .rstn, .vectorBaseAddress, .excReq, .dbgReq, .dbgLevel, .swiReq, .powerMonReq,
        .powerMonLevel, .clockLossReq, .clockLossLevel, .convLimitReq, .periphReq, .periphLevel, .softLowReq,
        .coreAck, .irqValid, .irqAddr, .irqVector, .chipResetAddr, .wdogResetAddr);
    core_model u_core (.clk, .rstn, .irqValid, .ackDelay, .coreAck);
    // --------------------------------
    // helpers
    // --------------------------------
    always #10 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_fail++;
            wrap_up();
        end
    end
    task automatic check(input logic [20:0] got, input logic [20:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // source drops its line once served
    task automatic clr(input int v);
        if (v < 6) excReq[v-2] <= 1'b0;
        else if (v < 11) dbgReq[v-6] <= 1'b0;
        else if (v < 14) swiReq[13-v] <= 1'b0;
        else if (v == 14) powerMonReq <= 1'b0;
        else if (v == 15) clockLossReq <= 1'b0;
        else if (v == 66) softLowReq <= 1'b0;
        else periphReq[v-16] <= 1'b0;
        if (v == 22) convLimitReq <= 3'h0;
    endtask
    // wait for the ack edge, judge what was presented there
    task automatic serve(input int v);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!(irqValid === 1'b1 && coreAck === 1'b1) && n < 40);
        check(21'(irqValid === 1'b1 && coreAck === 1'b1), 21'h000001);
        check(21'(irqVector), 21'(v));
        check(irqAddr, (vectorBaseAddress + 21'(2 * v)) & 21'h07ffff);
        clr(v);
    endtask
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic s_resets();
        @(posedge clk);
        check(chipResetAddr, 21'h000000);
        check(wdogResetAddr, 21'h000002);
        vectorBaseAddress <= 21'h07ffc0;
        @(posedge clk);
        @(posedge clk);
        check(chipResetAddr, 21'h07ffc0);
        check(wdogResetAddr, 21'h07ffc2);
    endtask
    task automatic s_exc();
        ackDelay <= 4'h3;
        excReq <= 4'hf;
        for (int v = 2; v < 6; v++) serve(v);
    endtask
    // every level from three down to minus one, mixed source kinds
    task automatic s_levels();
        ackDelay <= 4'h0;
        dbgLevel <= 10'h0c0;
        dbgReq <= 5'h08;
        swiReq <= 3'h7;
        powerMonReq <= 1'b1;
        clockLossLevel <= 2'h3;
        clockLossReq <= 1'b1;
        periphLevel[13:12] <= 2'h2;
        convLimitReq <= 3'h4;
        softLowReq <= 1'b1;
        foreach (ordA[i]) serve(ordA[i]);
    endtask
    task automatic s_flash();
        periphLevel[59:58] <= 2'h2;
        periphLevel[61:60] <= 2'h1;
        periphLevel[79:78] <= 2'h1;
        periphReq[31:29] <= 3'h7;
        periphReq[39] <= 1'b1;
        foreach (ordB[i]) serve(ordB[i]);
    endtask
    // reset while a vector is presented clears the handshake outputs
    task automatic s_midreset();
        ackDelay <= 4'hf;
        excReq <= 4'h1;
        repeat (4) @(posedge clk);
        rstn <= 1'b0;
        @(posedge clk);
        check(21'(irqValid), 21'h000000);
        check(irqAddr, 21'h000000);
        check(21'(irqVector), 21'h000000);
        rstn <= 1'b1;
        serve(2);
    endtask
    task automatic wrap_up();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        s_resets();
        s_exc();
        s_levels();
        s_flash();
        s_midreset();
        wrap_up();
    end
endmodule
